// file: tcpw_pkg.sv
// Purpose: constants shared by the timer/counter unit
// Assumes: register byte address is four times the register index
// Notes:   8-bit registers sit in the low byte of a 32-bit word
package tcpw_pkg;

  // register indices
  localparam logic [7:0] IDX_CNT1_LO   = 8'h2C;
  localparam logic [7:0] IDX_CNT1_HI   = 8'h2D;
  localparam logic [7:0] IDX_ASYNC_ST  = 8'h30;
  localparam logic [7:0] IDX_CTRL0     = 8'h33;
  localparam logic [7:0] IDX_CNT0      = 8'h32;
  localparam logic [7:0] IDX_CMP0      = 8'h31;
  localparam logic [7:0] IDX_CTRL2     = 8'h25;
  localparam logic [7:0] IDX_CNT2      = 8'h24;
  localparam logic [7:0] IDX_CMP2      = 8'h23;
  localparam logic [7:0] IDX_FLAG      = 8'h36;
  localparam logic [7:0] IDX_MASK      = 8'h37;
  localparam logic [7:0] IDX_CTRL1     = 8'h2E;
  localparam logic [7:0] IDX_CMP1A_LO  = 8'h2A;
  localparam logic [7:0] IDX_CMP1A_HI  = 8'h2B;
  localparam logic [7:0] IDX_CMP1B_LO  = 8'h28;
  localparam logic [7:0] IDX_CMP1B_HI  = 8'h29;
  localparam logic [7:0] IDX_CAP1_LO   = 8'h26;
  localparam logic [7:0] IDX_CAP1_HI   = 8'h27;

  // 8-bit counter control fields
  localparam int CTL_PWM_BIT     = 6;
  localparam int CTL_COM_HI_BIT  = 5;
  localparam int CTL_COM_LO_BIT  = 4;
  localparam int CTL_CLR_BIT     = 3;
  localparam int CTL_CS_MSB      = 2;

  // async status fields
  localparam int AST_SEL_BIT     = 3;
  localparam int AST_CNT_BSY_BIT = 2;
  localparam int AST_CMP_BSY_BIT = 1;
  localparam int AST_CTL_BSY_BIT = 0;

  // flag and mask fields
  localparam int FL_OVF0   = 0;
  localparam int FL_CMP0   = 1;
  localparam int FL_OVF1   = 2;
  localparam int FL_CMP1B  = 3;
  localparam int FL_CMP1A  = 4;
  localparam int FL_CAP1   = 5;
  localparam int FL_OVF2   = 6;
  localparam int FL_CMP2   = 7;

  // clock select codes of counters 1 and 2
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_CK     = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_PIN_FALL = 3'h6;
  localparam logic [2:0] CS_PIN_RISE = 3'h7;

  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  CNT_TOP   = 8'hFF;
  localparam logic [7:0]  CNT_BOT   = 8'h00;
  localparam int          PRE_W     = 10;
  localparam int          PWM_PERIOD = 510;
  localparam real         OSC_KHZ   = 32.768;

endpackage : tcpw_pkg

// file: tcpw_timer.sv
// Purpose: two 8-bit and one 16-bit timer/counter behind an AHB-Lite slave
// Assumes: pins are asynchronous and pass three flip-flops
// Notes:   one wait state on every bus transfer
// Summary of operation
// - three counters: counter 0 and 2 are 8-bit, counter 1 is 16-bit
// - counter 0 may count a separate 32.768 kHz oscillator via its own prescaler
// - counters 1 and 2 pick taps 8, 64, 256, 1024 of one shared 10-bit prescaler
// - counters 1 and 2 may also use the core clock, a pin, or stop
// - counter 0 counts its prescaler input undivided or divided; 0 and 2 can stop
// - all status flags sit in one flag register, enables in one mask register
// - counter 2 pin clock is sampled on every rising core clock edge
// - counters 0 and 2 compare; a match may clear the count and drive the pin
// - counters 0 and 2 offer glitch-free centre-aligned 8-bit PWM
// - in PWM mode a compare read returns the last written buffered value
// - active compare 00 or FF forces the PWM pin at once, per output mode
// - PWM overflow flag sets when counting from 00; requests need both enables
// - PWM frequency is the timer clock divided by 510
// - async status: bits 7..4 zero, bit 3 read/write, bits 2..0 busy, reset zero
// - counter 1 clock codes: stop, ck, /8, /64, /256, /1024, pin fall, pin rise
// - pin clock modes count pin edges even when the pin is an output
// - counter 1 wide registers move through one shared 8-bit byte latch
// - high byte write fills the latch; low byte write loads all 16 bits
// - low byte read copies the high byte to the latch; high read returns latch
//
// The AHB-Lite interface to the registers was decided locally.
module tcpw_timer
  import tcpw_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RSTN,
  input  wire logic              I_HSEL,
  input  wire logic [ADDR_W-1:0] I_HADDR,
  input  wire logic [1:0]        I_HTRANS,
  input  wire logic              I_HWRITE,
  input  wire logic [2:0]        I_HSIZE,
  input  wire logic [31:0]       I_HWDATA,
  input  wire logic              I_HREADY,
  output logic      [31:0]       O_HRDATA,
  output logic                   O_HREADYOUT,
  output logic                   O_HRESP,
  input  wire logic              I_ASYNC_OSC,
  input  wire logic              I_COUNT_PIN_ONE,
  input  wire logic              I_COUNT_PIN_TWO,
  input  wire logic              I_CAPTURE_PIN,
  input  wire logic              I_GLOBAL_IE,
  output logic                   O_COMPARE_OUT_ZERO,
  output logic                   O_COMPARE_OUT_TWO,
  output logic      [7:0]        O_IRQ_REQ
);

  // bus slave: address phase captured, access done one cycle later
  logic       pend_r;
  logic       pwr_r;
  logic [7:0] pidx_r;
  logic       acc;
  logic       acc_wr;
  logic       acc_rd;
  logic [7:0] wdat;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      pend_r      <= 1'b0;
      pwr_r       <= 1'b0;
      pidx_r      <= RST_BYTE;
      O_HREADYOUT <= 1'b1;
    end
    else if (I_HSEL && I_HTRANS[1] && I_HREADY)
    begin
      pend_r      <= 1'b1;
      pwr_r       <= I_HWRITE;
      pidx_r      <= I_HADDR[9:2];
      O_HREADYOUT <= 1'b0;
    end
    else
    begin
      pend_r      <= 1'b0;
      O_HREADYOUT <= 1'b1;
    end
  end

  assign O_HRESP = 1'b0;
  assign acc     = pend_r;
  assign acc_wr  = pend_r && pwr_r;
  assign acc_rd  = pend_r && !pwr_r;
  assign wdat    = I_HWDATA[7:0];

  // pin synchronisers: a change counts when stages 2 and 3 agree
  logic [3:0] pin_in;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] lvl_r;
  logic [3:0] rise_r;
  logic [3:0] fall_r;

  assign pin_in = {I_CAPTURE_PIN, I_COUNT_PIN_TWO, I_COUNT_PIN_ONE, I_ASYNC_OSC};

  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_sync
      always_ff @(posedge I_CORE_CLK)
      begin
        if (!I_RSTN)
        begin
          s1_r[p]   <= 1'b0;
          s2_r[p]   <= 1'b0;
          s3_r[p]   <= 1'b0;
          lvl_r[p]  <= 1'b0;
          rise_r[p] <= 1'b0;
          fall_r[p] <= 1'b0;
        end
        else
        begin
          s1_r[p]   <= pin_in[p];
          s2_r[p]   <= s1_r[p];
          s3_r[p]   <= s2_r[p];
          rise_r[p] <= (s2_r[p] == s3_r[p]) && s3_r[p] && !lvl_r[p];
          fall_r[p] <= (s2_r[p] == s3_r[p]) && !s3_r[p] && lvl_r[p];
          if (s2_r[p] == s3_r[p])
          begin
            lvl_r[p] <= s3_r[p];
          end
        end
      end
    end
  endgenerate

  // shared prescaler of counters 1 and 2, and counter 0's own prescaler
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre0_r;
  logic [7:0]       ast_r;
  logic             base0;
  logic [4:0]       tap;
  logic [7:0]       tap0;

  assign base0 = ast_r[AST_SEL_BIT] ? rise_r[0] : 1'b1;
  assign tap   = {&pre_r[9:0], &pre_r[7:0], &pre_r[5:0], &pre_r[2:0], 1'b1};
  assign tap0  = {base0 & (&pre0_r[9:0]), base0 & (&pre0_r[7:0]),
                  base0 & (&pre0_r[6:0]), base0 & (&pre0_r[5:0]),
                  base0 & (&pre0_r[4:0]), base0 & (&pre0_r[2:0]), base0, 1'b0};

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      pre_r <= '0;
    end
    else
    begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      pre0_r <= '0;
    end
    else if (base0)
    begin
      pre0_r <= pre0_r + 1'b1;
    end
  end

  // tick of counter 1 or 2 from its clock select code
  function automatic logic sel_tick(input logic [2:0] cs, input logic [4:0] tp,
                                    input logic rs, input logic fl);
    logic t;
    t = 1'b0;
    case (cs)
      CS_STOP:     t = 1'b0;
      CS_CK:       t = tp[0];
      CS_DIV8:     t = tp[1];
      CS_DIV64:    t = tp[2];
      CS_DIV256:   t = tp[3];
      CS_DIV1K:    t = tp[4];
      CS_PIN_FALL: t = fl;
      CS_PIN_RISE: t = rs;
      default:     t = 1'b0;
    endcase
    return t;
  endfunction : sel_tick

  // flags, mask and request outputs
  logic [7:0] flag_r;
  logic [7:0] mask_r;
  logic [7:0] fset;
  logic [7:0] fclr;

  assign fclr = (acc_wr && pidx_r == IDX_FLAG) ? wdat : 8'h00;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      flag_r    <= RST_BYTE;
      mask_r    <= RST_BYTE;
      O_IRQ_REQ <= RST_BYTE;
    end
    else
    begin
      flag_r    <= (flag_r & ~fclr) | fset;
      O_IRQ_REQ <= flag_r & mask_r & {8{I_GLOBAL_IE}};
      if (acc_wr && pidx_r == IDX_MASK)
      begin
        mask_r <= wdat;
      end
    end
  end

  // async status: select bit and update-busy bits
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      ast_r <= RST_BYTE;
    end
    else
    begin
      if (acc_wr && pidx_r == IDX_ASYNC_ST)
      begin
        ast_r[AST_SEL_BIT] <= wdat[AST_SEL_BIT];
      end
      if (ast_r[AST_SEL_BIT] && rise_r[0])
      begin
        ast_r[2:0] <= 3'h0;
      end
      if (ast_r[AST_SEL_BIT] && acc_wr)
      begin
        if (pidx_r == IDX_CNT0)
        begin
          ast_r[AST_CNT_BSY_BIT] <= 1'b1;
        end
        if (pidx_r == IDX_CMP0)
        begin
          ast_r[AST_CMP_BSY_BIT] <= 1'b1;
        end
        if (pidx_r == IDX_CTRL0)
        begin
          ast_r[AST_CTL_BSY_BIT] <= 1'b1;
        end
      end
    end
  end

  // counters 0 and 2
  logic [7:0] ctl8_r [2];
  logic [7:0] cnt8_r [2];
  logic [7:0] cmp8_r [2];
  logic [7:0] buf8_r [2];
  logic       dn8_r  [2];
  logic       out8_r [2];
  logic [1:0] ovf8;
  logic [1:0] mat8;

  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_c8
      localparam logic [7:0] LI_CTL = (c == 0) ? IDX_CTRL0 : IDX_CTRL2;
      localparam logic [7:0] LI_CNT = (c == 0) ? IDX_CNT0 : IDX_CNT2;
      localparam logic [7:0] LI_CMP = (c == 0) ? IDX_CMP0 : IDX_CMP2;
      logic       tick;
      logic       pwm;
      logic [1:0] com;
      logic [7:0] nxt;
      logic       dnx;

      assign pwm  = ctl8_r[c][CTL_PWM_BIT];
      assign com  = {ctl8_r[c][CTL_COM_HI_BIT], ctl8_r[c][CTL_COM_LO_BIT]};
      assign tick = (c == 0) ? tap0[ctl8_r[c][CTL_CS_MSB:0]]
                  : sel_tick(ctl8_r[c][CTL_CS_MSB:0], tap, rise_r[2], fall_r[2]);

      always_comb
      begin
        nxt = cnt8_r[c] + 8'h01;
        dnx = dn8_r[c];
        if (pwm)
        begin
          if (!dn8_r[c] && cnt8_r[c] == CNT_TOP)
          begin
            nxt = cnt8_r[c] - 8'h01;
            dnx = 1'b1;
          end
          else if (dn8_r[c] && cnt8_r[c] == CNT_BOT)
          begin
            dnx = 1'b0;
          end
          else if (dn8_r[c])
          begin
            nxt = cnt8_r[c] - 8'h01;
          end
        end
        else if (ctl8_r[c][CTL_CLR_BIT] && cnt8_r[c] == cmp8_r[c])
        begin
          nxt = CNT_BOT;
        end
      end

      assign ovf8[c] = tick && (pwm ? (cnt8_r[c] == CNT_BOT)
                                    : (cnt8_r[c] == CNT_TOP && nxt == CNT_BOT));
      assign mat8[c] = tick && (pwm ? (nxt == cmp8_r[c]) : (cnt8_r[c] == cmp8_r[c]));

      always_ff @(posedge I_CORE_CLK)
      begin
        if (!I_RSTN)
        begin
          ctl8_r[c] <= RST_BYTE;
          cnt8_r[c] <= RST_BYTE;
          cmp8_r[c] <= RST_BYTE;
          buf8_r[c] <= RST_BYTE;
          dn8_r[c]  <= 1'b0;
        end
        else
        begin
          if (acc_wr && pidx_r == LI_CTL)
          begin
            ctl8_r[c] <= wdat;
          end
          if (acc_wr && pidx_r == LI_CNT)
          begin
            cnt8_r[c] <= wdat;
          end
          else if (tick)
          begin
            cnt8_r[c] <= nxt;
            dn8_r[c]  <= dnx;
          end
          if (!pwm)
          begin
            dn8_r[c] <= 1'b0;
          end
          if (acc_wr && pidx_r == LI_CMP)
          begin
            buf8_r[c] <= wdat;
            if (!pwm)
            begin
              cmp8_r[c] <= wdat;
            end
          end
          else if (pwm && tick && !dn8_r[c] && cnt8_r[c] == CNT_TOP)
          begin
            cmp8_r[c] <= buf8_r[c];
          end
        end
      end

      always_ff @(posedge I_CORE_CLK)
      begin
        if (!I_RSTN)
        begin
          out8_r[c] <= 1'b0;
        end
        else if (pwm && com[1] && (cmp8_r[c] == CNT_BOT || cmp8_r[c] == CNT_TOP))
        begin
          out8_r[c] <= (cmp8_r[c] == CNT_TOP) ^ com[0];
        end
        else if (mat8[c] && pwm && com[1])
        begin
          out8_r[c] <= dnx ^ com[0];
        end
        else if (mat8[c] && !pwm)
        begin
          case (com)
            2'h1:    out8_r[c] <= !out8_r[c];
            2'h2:    out8_r[c] <= 1'b0;
            2'h3:    out8_r[c] <= 1'b1;
            default: out8_r[c] <= out8_r[c];
          endcase
        end
      end
    end
  endgenerate

  assign O_COMPARE_OUT_ZERO = out8_r[0];
  assign O_COMPARE_OUT_TWO  = out8_r[1];

  // counter 1 with shared byte latch
  logic [7:0]  ctl1_r;
  logic [15:0] cnt1_r;
  logic [15:0] cmpa_r;
  logic [15:0] cmpb_r;
  logic [15:0] cap_r;
  logic [7:0]  tmp_r;
  logic        tick1;

  assign tick1 = sel_tick(ctl1_r[2:0], tap, rise_r[1], fall_r[1]);

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      ctl1_r <= RST_BYTE;
      cnt1_r <= RST_WORD;
      cmpa_r <= RST_WORD;
      cmpb_r <= RST_WORD;
      cap_r  <= RST_WORD;
    end
    else
    begin
      if (acc_wr && pidx_r == IDX_CTRL1)
      begin
        ctl1_r <= wdat;
      end
      if (acc_wr && pidx_r == IDX_CNT1_LO)
      begin
        cnt1_r <= {tmp_r, wdat};
      end
      else if (tick1)
      begin
        cnt1_r <= cnt1_r + 16'h0001;
      end
      if (acc_wr && pidx_r == IDX_CMP1A_LO)
      begin
        cmpa_r <= {tmp_r, wdat};
      end
      if (acc_wr && pidx_r == IDX_CMP1B_LO)
      begin
        cmpb_r <= {tmp_r, wdat};
      end
      if (rise_r[3])
      begin
        cap_r <= cnt1_r;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      tmp_r <= RST_BYTE;
    end
    else if (acc_wr && (pidx_r == IDX_CNT1_HI || pidx_r == IDX_CMP1A_HI
                        || pidx_r == IDX_CMP1B_HI || pidx_r == IDX_CAP1_HI))
    begin
      tmp_r <= wdat;
    end
    else if (acc_rd)
    begin
      case (pidx_r)
        IDX_CNT1_LO:  tmp_r <= cnt1_r[15:8];
        IDX_CMP1A_LO: tmp_r <= cmpa_r[15:8];
        IDX_CMP1B_LO: tmp_r <= cmpb_r[15:8];
        IDX_CAP1_LO:  tmp_r <= cap_r[15:8];
        default:      tmp_r <= tmp_r;
      endcase
    end
  end

  assign fset = {mat8[1], ovf8[1], rise_r[3], tick1 && cnt1_r == cmpa_r,
                 tick1 && cnt1_r == cmpb_r, tick1 && cnt1_r == 16'hFFFF,
                 mat8[0], ovf8[0]};

  // read data
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      O_HRDATA <= 32'h0000_0000;
    end
    else if (acc)
    begin
      O_HRDATA <= 32'h0000_0000;
      if (acc_rd)
      begin
        case (pidx_r)
          IDX_CNT1_LO:  O_HRDATA[7:0] <= cnt1_r[7:0];
          IDX_CMP1A_LO: O_HRDATA[7:0] <= cmpa_r[7:0];
          IDX_CMP1B_LO: O_HRDATA[7:0] <= cmpb_r[7:0];
          IDX_CAP1_LO:  O_HRDATA[7:0] <= cap_r[7:0];
          IDX_CNT1_HI, IDX_CMP1A_HI, IDX_CMP1B_HI, IDX_CAP1_HI:
                        O_HRDATA[7:0] <= tmp_r;
          IDX_CTRL1:    O_HRDATA[7:0] <= ctl1_r;
          IDX_ASYNC_ST: O_HRDATA[7:0] <= {4'h0, ast_r[3:0]};
          IDX_CTRL0:    O_HRDATA[7:0] <= ctl8_r[0];
          IDX_CNT0:     O_HRDATA[7:0] <= cnt8_r[0];
          IDX_CMP0:     O_HRDATA[7:0] <= buf8_r[0];
          IDX_CTRL2:    O_HRDATA[7:0] <= ctl8_r[1];
          IDX_CNT2:     O_HRDATA[7:0] <= cnt8_r[1];
          IDX_CMP2:     O_HRDATA[7:0] <= buf8_r[1];
          IDX_FLAG:     O_HRDATA[7:0] <= flag_r;
          IDX_MASK:     O_HRDATA[7:0] <= mask_r;
          default:      O_HRDATA[7:0] <= 8'h00;
        endcase
      end
    end
  end

endmodule : tcpw_timer

// file: tcpw_timer_properties.sv
// Purpose: port checks of the timer unit
// Assumes: hready is tied to hreadyout
// Notes:   one clock, synchronous active-low reset
module tcpw_timer_checker
  import tcpw_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input wire logic              I_CORE_CLK,
  input wire logic              I_RSTN,
  input wire logic              I_HSEL,
  input wire logic [ADDR_W-1:0] I_HADDR,
  input wire logic [1:0]        I_HTRANS,
  input wire logic              I_HWRITE,
  input wire logic              I_HREADY,
  input wire logic              I_GLOBAL_IE,
  input wire logic [31:0]       O_HRDATA,
  input wire logic              O_HREADYOUT,
  input wire logic              O_HRESP,
  input wire logic [7:0]        O_IRQ_REQ
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RSTN);

  logic take;
  assign take = I_HSEL && I_HTRANS[1] && I_HREADY;

  sequence s_rd;
    take && !I_HWRITE;
  endsequence
  sequence s_dphase;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence

  a_wait_state: assert property (take |=> s_dphase)
    else $error("transfer without one wait state");
  a_ready_cause: assert property ($fell(O_HREADYOUT) |-> $past(take))
    else $error("wait state without transfer");
  a_ready_hold: assert property (!O_HREADYOUT |=> O_HREADYOUT)
    else $error("wait state longer than one cycle");
  a_rdata_hold: assert property ($changed(O_HRDATA) |-> !$past(O_HREADYOUT))
    else $error("read data moved outside a data phase");
  a_irq_gate: assert property (|O_IRQ_REQ |-> $past(I_GLOBAL_IE))
    else $error("request without global enable");
  a_rdata_width: assert property (O_HRDATA[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_async_rsvd: assert property (s_rd ##0 I_HADDR[9:2] == IDX_ASYNC_ST |=>
    s_dphase ##0 O_HRDATA[7:4] == 4'h0)
    else $error("reserved status bits not zero");
  a_unmapped_zero: assert property (s_rd ##0 I_HADDR[9:2] > IDX_MASK |=>
    s_dphase ##0 O_HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_resp_okay: assert property (O_HRESP == 1'b0)
    else $error("error response on the bus");
endmodule : tcpw_timer_checker

// file: tcpw_pin_model.sv
// Purpose: pin-side model: count pins, oscillator, capture pin
// Assumes: pins change right after a core clock edge
// Notes:   oscillator period is shortened to keep runs brief
module tcpw_pin_model
#(
  parameter int OSC_HALF_NS = 160
)(
  input  wire logic i_clk,
  output logic      o_count_one,
  output logic      o_count_two,
  output logic      o_osc,
  output logic      o_capture
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_count_one = 1'b0;
    o_count_two = 1'b0;
    o_osc       = 1'b0;
    o_capture   = 1'b0;
  end

  // crystal oscillator runs free
  always #(OSC_HALF_NS) o_osc = ~o_osc;

  // edges kept several core cycles apart
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_count_one <= 1'b1;
      o_count_two <= 1'b1;
      o_capture   <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_count_one <= 1'b0;
      o_count_two <= 1'b0;
      o_capture   <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask : pulse
endmodule : tcpw_pin_model

// file: tcpw_timer_bench.sv
// Purpose: self-checking bench of the timer unit
// Assumes: one slave, hready tied to hreadyout
// Notes:   bus reads are checked by a monitor from a queue of notes
module tcpw_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcpw_pkg::*;

  typedef struct {logic [7:0] v; logic [7:0] m; int tol;} tcpw_exp_t;
  localparam int OSC_HALF = 160;

  logic        core_clk = 1'b0;
  logic        rstn;
  logic        hsel;
  logic        hwrite;
  logic        global_ie;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        out_zero;
  logic        out_two;
  logic [7:0]  irq_req;
  logic        cnt_one;
  logic        cnt_two;
  logic        osc;
  logic        capture;
  logic        rd_pend = 1'b0;
  tcpw_exp_t   exp_q[$];
  tcpw_exp_t   e;
  int          fail_count = 0;
  int          check_count = 0;
  int          divs[6] = '{1, 1, 8, 64, 256, 1024};

  always #10 core_clk = ~core_clk;

  tcpw_timer tcpw_timer_i (
    .I_CORE_CLK(core_clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
    .O_HRESP(), .I_ASYNC_OSC(osc), .I_COUNT_PIN_ONE(cnt_one),
    .I_COUNT_PIN_TWO(cnt_two), .I_CAPTURE_PIN(capture), .I_GLOBAL_IE(global_ie),
    .O_COMPARE_OUT_ZERO(out_zero), .O_COMPARE_OUT_TWO(out_two), .O_IRQ_REQ(irq_req)
  );

  tcpw_pin_model #(.OSC_HALF_NS(OSC_HALF)) tcpw_pin_model_i (
    .i_clk(core_clk), .o_count_one(cnt_one), .o_count_two(cnt_two),
    .o_osc(osc), .o_capture(capture)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      fail_count++;
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {2'b00, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] v, input logic [7:0] m,
                    input int tol);
    exp_q.push_back('{v, m, tol});
    bus(1'b0, idx, 8'h00);
  endtask : rd

  // cycles between two rising edges of a compare pin
  task automatic rise_gap(input logic two, output int c);
    logic p;
    logic q;
    int   k;
    int   t;
    c = 0;
    k = 0;
    t = 0;
    p = two ? out_two : out_zero;
    while (k < 2 && t < 3000)
    begin
      @(posedge core_clk);
      t++;
      q = two ? out_two : out_zero;
      if (k == 1)
        c++;
      if (q === 1'b1 && p === 1'b0)
        k++;
      p = q;
    end
  endtask : rise_gap

  always @(posedge core_clk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      e = exp_q.pop_front();
      if (e.tol == 0)
        check(hrdata & {24'h0, e.m}, {24'h0, e.v & e.m});
      else
        check(32'(hrdata[7:0] + e.tol >= e.v && hrdata[7:0] <= e.v + e.tol), 32'h1);
    end
    rd_pend <= (hsel && htrans[1] && hreadyout) ? !hwrite : (hreadyout ? 1'b0 : rd_pend);
  end

  initial
  begin
    logic [15:0] v;
    logic [7:0]  b;
    logic [7:0]  ci;
    logic [7:0]  mi;
    logic [7:0]  msk;
    int          g;
    void'($urandom(3902));
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 12'h000;
    hsize = 3'h2;
    hwdata = 32'h0;
    global_ie = 1'b0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(IDX_CNT1_LO, 8'h00, 8'hFF, 0);
    rd(IDX_CNT1_HI, 8'h00, 8'hFF, 0);
    rd(IDX_ASYNC_ST, 8'h00, 8'hFF, 0);
    wr(IDX_ASYNC_ST, 8'hFF);
    rd(IDX_ASYNC_ST, 8'h08, 8'hFF, 0);
    wr(IDX_ASYNC_ST, 8'h00);
    wr(8'h3F, 8'h5A);
    rd(8'h3F, 8'h00, 8'hFF, 0);
    $display("test registers done");
    v = 16'($urandom);
    b = 8'($urandom);
    wr(IDX_CNT1_HI, v[15:8]);
    wr(IDX_CNT1_LO, v[7:0]);
    wr(IDX_CNT1_HI, ~v[15:8]);
    rd(IDX_CNT1_LO, v[7:0], 8'hFF, 0);
    rd(IDX_CNT1_HI, v[15:8], 8'hFF, 0);
    wr(IDX_CNT1_LO, b);
    rd(IDX_CNT1_LO, b, 8'hFF, 0);
    rd(IDX_CNT1_HI, v[15:8], 8'hFF, 0);
    $display("test byte latch done");
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_CNT1_HI, 8'h00);
      wr(IDX_CNT1_LO, 8'h00);
      wr(IDX_CTRL1, 8'(c));
      if (c < 6)
        repeat (20 * divs[c]) @(posedge core_clk);
      else
        tcpw_pin_model_i.pulse(5);
      repeat (8) @(posedge core_clk);
      wr(IDX_CTRL1, 8'(CS_STOP));
      // prescaled window spans 20 taps plus about 11 cycles: the 8-cycle wait and about 3 of bus overhead
      g = (c == 0) ? 0 : (c == 1) ? 30 : (c < 6) ? 21 : 5;
      rd(IDX_CNT1_LO, 8'(g), 8'hFF, (c == 1) ? 3 : (c < 6 && c > 1) ? 1 : 0);
    end
    // capture edges came with the count edges; the last one saw a count of about 4
    rd(IDX_CAP1_LO, 8'h04, 8'hFF, 1);
    rd(IDX_CAP1_HI, 8'h00, 8'hFF, 0);
    rd(IDX_FLAG, 8'h20, 8'h20, 0);
    wr(IDX_CNT2, 8'h00);
    wr(IDX_CTRL2, 8'(CS_PIN_RISE));
    tcpw_pin_model_i.pulse(6);
    repeat (8) @(posedge core_clk);
    wr(IDX_CTRL2, 8'h00);
    rd(IDX_CNT2, 8'h06, 8'hFF, 0);
    wr(IDX_ASYNC_ST, 8'h08);
    wr(IDX_CNT0, 8'h00);
    wr(IDX_CTRL0, 8'h01);
    repeat (20 * OSC_HALF / 10) @(posedge core_clk);
    wr(IDX_CTRL0, 8'h00);
    rd(IDX_CNT0, 8'd20, 8'hFF, 2);
    wr(IDX_ASYNC_ST, 8'h00);
    $display("test clock sources done");
    global_ie <= 1'b1;
    for (int n = 0; n < 2; n++)
    begin
      ci = n ? IDX_CTRL2 : IDX_CTRL0;
      mi = n ? IDX_CMP2 : IDX_CMP0;
      msk = n ? 8'h40 : 8'h01;
      for (int k = 0; k < 4; k++)
      begin
        wr(ci, {2'b01, 1'b1, k[1], 1'b0, 3'h1});
        wr(mi, k[0] ? CNT_TOP : CNT_BOT);
        rd(mi, k[0] ? CNT_TOP : CNT_BOT, 8'hFF, 0);
        repeat (600) @(posedge core_clk);
        check(32'(n ? out_two : out_zero), 32'(k[0] ^ k[1]));
      end
      wr(ci, 8'h61);
      wr(mi, 8'h80);
      rise_gap(n[0], g);
      check(g, PWM_PERIOD);
      wr(IDX_MASK, msk);
      wr(IDX_FLAG, 8'hFF);
      repeat (600) @(posedge core_clk);
      rd(IDX_FLAG, msk, msk, 0);
      check(irq_req & msk, msk);
      global_ie <= 1'b0;
      repeat (3) @(posedge core_clk);
      check(irq_req, 8'h00);
      global_ie <= 1'b1;
      wr(ci, 8'h00);
    end
    $display("test pwm done");
    wr(IDX_CNT2, 8'h00);
    wr(IDX_CMP2, 8'h09);
    wr(IDX_CTRL2, 8'h19);
    rise_gap(1'b1, g);
    check(g, 20);
    $display("test compare done");
    conclude();
  end

  initial
  begin
    repeat (80000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule : tcpw_timer_bench

bind tcpw_timer tcpw_timer_checker #(.ADDR_W(ADDR_W)) tcpw_timer_checker_i (
  .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
  .I_GLOBAL_IE(I_GLOBAL_IE), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP),
  .O_IRQ_REQ(O_IRQ_REQ)
);
